// file: core/uart_mic_consts.svh
// Constants for the modem, interrupt and turnaround control block.
// Assumes a 250 MHz clock and a 32-bit Avalon-MM register port.
// Function
// - Enable bits select four interrupt groups.
// - Disabled interrupts hidden; status still updates.
// - Control bit0 drives inverted terminal-ready pin.
// - Control bit1 drives inverted request-to-send pin.
// - Control bit2 is pinless user output.
// - Control bit3 gates interrupt request line.
// - Control bit4 selects internal loopback wiring.
// - Loopback holds modem output pins high.
// - Loopback modem interrupts come from control bits.
// - Loopback floats the interrupt request pin.
// - Test-mode bit acts as loopback bit unless infrared mode is set.
// - Control bits 7..5 read zero.
// - Identification code shows highest pending interrupt.
// - Each interrupt clears on its own access.
// - Timeout after four idle character times.
// - Change flags set on change, clear on read.
// - Ring flag sets on trailing edge only.
// - Status high nibble shows inverted modem inputs.
// - Infrared mode forces pin defaults.
// - Half duplex blocks receiver while transmitting.
// - Turnaround timeout blocks after direction change.
// - Transmit held until receive turnaround expires.
// - Scratch register stores data, no effect.
// - FIFO enable bit selects FIFO mode.
`ifndef UART_MIC_CONSTS_SVH
`define UART_MIC_CONSTS_SVH
`define ADDR_IRQ_ENABLE 4'h1
`define ADDR_IRQ_IDENT 4'h2
`define ADDR_LINE_CTRL_OUT 4'h4
`define ADDR_LINE_STATE_IN 4'h6
`define ADDR_SCRATCH 4'h7
`define ADDR_PORT_MODE 4'h8
`define ADDR_FIFO_CTRL 4'h9
`define IDENT_NONE 4'h1
`define IDENT_LINE 4'h6
`define IDENT_DATA 4'h4
`define IDENT_TIMEOUT 4'hc
`define IDENT_THRE 4'h2
`define IDENT_MODEM 4'h0
`define MODE_TEST 0
`define MODE_INFRARED 1
`define MODE_HALF_DUPLEX 2
`define TURN_RX_TO_TX_BITS 15
`define TURN_TX_TO_RX_NS 70
`define CLK_PERIOD_NS 4
`define TURN_TX_TO_RX_CYC ((`TURN_TX_TO_RX_NS) / (`CLK_PERIOD_NS))
`define CHAR_TIMEOUT_CHARS 4
`endif

// file: core/uart_mic_pkg.sv
// Types shared by the modem, interrupt and turnaround control block.
// Assumes nothing beyond the constants header.
package uart_mic_pkg;
    typedef enum logic [1:0] {
        turn_idle,
        turn_after_tx,
        turn_after_rx
    } turn_state_t;
    typedef logic [7:0] byte_t;
endpackage

// file: core/uart_modem_interrupt_control.sv
// Modem control/status, interrupt enable/identification, scratch register
// and half-duplex turnaround of a FIFO serial port, behind Avalon-MM.
// Assumes the transmitter, receiver and FIFOs are outside and report events
// as one-cycle pulses or levels on the same clock; modem pins are asynchronous.
//
// The register offsets and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/100ps
`include "uart_mic_consts.svh"
module uart_modem_interrupt_control #(
    parameter int BIT_CYCLES = 136
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic line_error_i,
    input wire logic line_state_read_i,
    input wire logic rx_data_ready_i,
    input wire logic rx_buffer_read_i,
    input wire logic rx_fifo_nonempty_i,
    input wire logic rx_fifo_push_i,
    input wire logic thr_empty_i,
    input wire logic thr_write_i,
    input wire logic tx_busy_i,
    input wire logic tx_pending_i,
    input wire logic tx_shift_i,
    input wire logic rx_busy_i,
    input wire logic cts_n_i,
    input wire logic dsr_n_i,
    input wire logic ring_in_n_i,
    input wire logic carrier_detect_in_n_i,
    input wire logic serial_rx_pin_i,
    input wire logic infrared_rx_pin_i,
    input wire logic infrared_rx_decoded_i,
    input wire logic tx_serial_i,
    input wire logic infrared_tx_encoded_i,
    output logic dtr_n_o,
    output logic rts_n_o,
    output logic serial_tx_pin_o,
    output logic infrared_tx_pin_o,
    output logic rx_serial_o,
    output logic tx_start_ok_o,
    output logic fifo_mode_o,
    output logic loopback_o,
    output logic irq_o,
    output logic irq_oe_n_o,
    output logic [3:0] irq_ident_o
);
    import uart_mic_pkg::*;

    localparam int CHAR_CYCLES = BIT_CYCLES * 10;
    localparam int TIMEOUT_CYCLES = CHAR_CYCLES * `CHAR_TIMEOUT_CHARS;
    localparam int RX_TO_TX_CYCLES = BIT_CYCLES * `TURN_RX_TO_TX_BITS;
    localparam int TX_TO_RX_CYCLES = (`TURN_TX_TO_RX_CYC < 1) ? 1 : `TURN_TX_TO_RX_CYC;

    // Counters are 32 bits wide; bit times are limited to 1 to 100000 cycles, so the timeout stays within 4000000
    if (BIT_CYCLES < 1 || BIT_CYCLES > 100000) begin : g_bit_cycles_check
        $error("BIT_CYCLES out of range");
    end

    byte_t irq_enable_reg;
    byte_t line_control_out_reg;
    byte_t scratchpad;
    logic [2:0] port_mode;
    logic fifo_enable_bit;
    logic [3:0] delta;
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] prev_state;
    logic prev_valid;
    logic [3:0] state_now;
    logic loop;
    logic infrared;
    logic thre_pend;
    logic timeout_pend;
    logic [31:0] idle_cnt;
    logic [3:0] ident;
    logic [3:0] ident_hold;
    logic rd_done;
    logic [31:0] rdata;
    logic acc;
    turn_state_t turn_state;
    logic [31:0] turn_cnt;
    logic tx_busy_d;
    logic rx_busy_d;
    logic [1:0] infrared_rx_pin_sync;
    logic [1:0] rx_sync;

    assign acc = avs_read_i | avs_write_i;
    // One wait cycle per access keeps read data registered
    assign avs_waitrequest_o = acc & ~rd_done;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || rd_done) begin
            rd_done <= 1'b0;
        end else begin
            rd_done <= acc;
        end
    end

    assign infrared = port_mode[`MODE_INFRARED];
    assign loop = line_control_out_reg[4] | (port_mode[`MODE_TEST] & ~infrared);
    assign loopback_o = loop;
    assign fifo_mode_o = fifo_enable_bit;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            irq_enable_reg <= 8'h00;
            line_control_out_reg <= 8'h00;
            scratchpad <= 8'h00;
            port_mode <= 3'h0;
            fifo_enable_bit <= 1'b0;
        end else if (avs_write_i && rd_done && avs_byteenable_i[0]) begin
            case (avs_address_i)
                `ADDR_IRQ_ENABLE: irq_enable_reg <= {4'h0, avs_writedata_i[3:0]};
                `ADDR_LINE_CTRL_OUT: line_control_out_reg <= {3'h0, avs_writedata_i[4:0]};
                `ADDR_SCRATCH: scratchpad <= avs_writedata_i[7:0];
                `ADDR_PORT_MODE: port_mode <= avs_writedata_i[2:0];
                `ADDR_FIFO_CTRL: fifo_enable_bit <= avs_writedata_i[0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            sync1 <= 4'hf;
            sync2 <= 4'hf;
            infrared_rx_pin_sync <= 2'b11;
            rx_sync <= 2'b11;
        end else begin
            sync1 <= {carrier_detect_in_n_i, ring_in_n_i, dsr_n_i, cts_n_i};
            sync2 <= sync1;
            infrared_rx_pin_sync <= {infrared_rx_pin_sync[0], infrared_rx_pin_i};
            rx_sync <= {rx_sync[0], serial_rx_pin_i};
        end
    end

    // State bits in order cts, dsr, ring, dcd (true polarity)
    always_comb begin
        if (loop) begin
            state_now = {line_control_out_reg[3], line_control_out_reg[2],
                         line_control_out_reg[0], line_control_out_reg[1]};
        end else if (infrared) begin
            state_now = 4'b0011;
        end else begin
            state_now = ~sync2;
        end
    end

    logic md_read;
    assign md_read = avs_read_i & rd_done & (avs_address_i == `ADDR_LINE_STATE_IN);

    logic [3:0] flag_seen;
    logic [3:0] flag_clr;
    // Only flags already shown in the read data are cleared, so a change
    // caught between capture and completion of the read is not lost
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            flag_seen <= 4'h0;
        end else if (avs_read_i && !rd_done) begin
            flag_seen <= delta;
        end
    end
    assign flag_clr = md_read ? flag_seen : 4'h0;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            delta <= 4'h0;
            prev_state <= 4'h0;
            prev_valid <= 1'b0;
        end else begin
            prev_state <= state_now;
            prev_valid <= 1'b1;
            // Set wins over the read clear
            delta[0] <= (prev_valid & (state_now[0] ^ prev_state[0])) | (delta[0] & ~flag_clr[0]);
            delta[1] <= (prev_valid & (state_now[1] ^ prev_state[1])) | (delta[1] & ~flag_clr[1]);
            delta[2] <= (prev_valid & prev_state[2] & ~state_now[2]) | (delta[2] & ~flag_clr[2]);
            delta[3] <= (prev_valid & (state_now[3] ^ prev_state[3])) | (delta[3] & ~flag_clr[3]);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            idle_cnt <= 32'h0;
            timeout_pend <= 1'b0;
        end else if (!fifo_enable_bit || !rx_fifo_nonempty_i || rx_fifo_push_i
                     || rx_buffer_read_i) begin
            idle_cnt <= 32'h0;
            timeout_pend <= 1'b0;
        end else if (idle_cnt >= 32'(TIMEOUT_CYCLES - 1)) begin
            timeout_pend <= 1'b1;
        end else begin
            idle_cnt <= idle_cnt + 32'h1;
        end
    end

    logic line_pend;
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            line_pend <= 1'b0;
        end else begin
            // An error still present at the status read keeps the flag up
            line_pend <= line_error_i | (line_pend & ~line_state_read_i);
        end
    end

    logic p_line;
    logic p_data;
    logic p_tout;
    logic p_thre;
    logic p_modem;
    assign p_line = irq_enable_reg[2] & line_pend;
    assign p_data = irq_enable_reg[0] & rx_data_ready_i;
    assign p_tout = irq_enable_reg[0] & timeout_pend;
    assign p_thre = irq_enable_reg[1] & thre_pend;
    assign p_modem = irq_enable_reg[3] & (|delta);

    always_comb begin
        if (p_line) begin
            ident = `IDENT_LINE;
        end else if (p_data) begin
            ident = `IDENT_DATA;
        end else if (p_tout) begin
            ident = `IDENT_TIMEOUT;
        end else if (p_thre) begin
            ident = `IDENT_THRE;
        end else if (p_modem) begin
            ident = `IDENT_MODEM;
        end else begin
            ident = `IDENT_NONE;
        end
    end

    // Identification read back from ident_hold frozen during an access to the identification register
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            ident_hold <= `IDENT_NONE;
        end else if (!(acc && avs_address_i == `ADDR_IRQ_IDENT)) begin
            ident_hold <= ident;
        end
    end
    assign irq_ident_o = ident;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            thre_pend <= 1'b0;
            tx_busy_d <= 1'b0;
        end else begin
            tx_busy_d <= thr_empty_i;
            if (thr_empty_i && !tx_busy_d) begin
                thre_pend <= 1'b1;
            end else if (thr_write_i) begin
                thre_pend <= 1'b0;
            end else if (avs_read_i && rd_done && avs_address_i == `ADDR_IRQ_IDENT
                         && ident_hold == `IDENT_THRE) begin
                thre_pend <= 1'b0;
            end
        end
    end

    assign irq_o = (ident != `IDENT_NONE) & line_control_out_reg[3];
    assign irq_oe_n_o = loop;

    assign dtr_n_o = loop | ~line_control_out_reg[0];
    assign rts_n_o = loop | ~line_control_out_reg[1];
    assign serial_tx_pin_o = (loop | infrared) ? 1'b1 : tx_serial_i;
    assign infrared_tx_pin_o = (infrared && !loop) ? infrared_tx_encoded_i : 1'b0;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            turn_state <= turn_idle;
            turn_cnt <= 32'h0;
            rx_busy_d <= 1'b0;
        end else begin
            rx_busy_d <= rx_busy_i;
            case (turn_state)
                turn_idle: begin
                    if (tx_busy_i) begin
                        turn_state <= turn_after_tx;
                        turn_cnt <= 32'(TX_TO_RX_CYCLES);
                    end else if (rx_busy_d && !rx_busy_i) begin
                        turn_state <= turn_after_rx;
                        turn_cnt <= 32'(RX_TO_TX_CYCLES);
                    end
                end
                turn_after_tx: begin
                    if (tx_busy_i) begin
                        turn_cnt <= 32'(TX_TO_RX_CYCLES);
                    end else if (turn_cnt <= 32'h1) begin
                        turn_state <= turn_idle;
                    end else begin
                        turn_cnt <= turn_cnt - 32'h1;
                    end
                end
                turn_after_rx: begin
                    if (rx_busy_i) begin
                        turn_cnt <= 32'(RX_TO_TX_CYCLES);
                    end else if (turn_cnt <= 32'h1) begin
                        turn_state <= turn_idle;
                    end else begin
                        turn_cnt <= turn_cnt - 32'h1;
                    end
                end
                default: turn_state <= turn_idle;
            endcase
        end
    end

    logic half;
    logic rx_src;
    assign half = port_mode[`MODE_HALF_DUPLEX];
    assign rx_src = infrared ? infrared_rx_pin_sync[1] & infrared_rx_decoded_i : rx_sync[1];
    // transmit hold
    // rx_busy_d covers the cycle before the timer state is entered
    assign tx_start_ok_o = ~half | ~(rx_busy_i | rx_busy_d | turn_state == turn_after_rx)
                           | ~tx_pending_i | tx_busy_i;

    always_comb begin
        if (loop) begin
            rx_serial_o = tx_shift_i;
        end else if (half && (tx_busy_i || turn_state == turn_after_tx)) begin
            rx_serial_o = 1'b1;
        end else begin
            rx_serial_o = rx_src;
        end
    end

    always_comb begin
        case (avs_address_i)
            `ADDR_IRQ_ENABLE: rdata = {24'h0, irq_enable_reg};
            `ADDR_IRQ_IDENT: rdata = {24'h0, {2{fifo_enable_bit}}, 2'b00,
                                      fifo_enable_bit ? ident_hold : (ident_hold & 4'h7)};
            `ADDR_LINE_CTRL_OUT: rdata = {24'h0, line_control_out_reg};
            `ADDR_LINE_STATE_IN: rdata = {24'h0, state_now, delta};
            `ADDR_SCRATCH: rdata = {24'h0, scratchpad};
            `ADDR_PORT_MODE: rdata = {29'h0, port_mode};
            `ADDR_FIFO_CTRL: rdata = {31'h0, fifo_enable_bit};
            default: rdata = 32'h0;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            avs_readdata_o <= 32'h0;
        end else if (avs_read_i && !rd_done) begin
            avs_readdata_o <= rdata;
        end
    end
endmodule

// file: tb/test_uart_modem_interrupt_control.sv
// Self-checking bench for the modem, interrupt and turnaround control block.
// Assumes the modem model on the handshake pins and a bit time of 4 clocks.
`timescale 1ns/100ps
module test_uart_modem_interrupt_control;
    import uart_mic_pkg::*;
    logic mclk_i = 1'h0;
    logic sys_rst_i = 1'h1;
    logic [3:0] avs_address_i = 4'h0;
    logic [3:0] avs_byteenable_i = 4'hf;
    logic [31:0] avs_writedata_i = 32'h0;
    logic avs_read_i = 1'h0, avs_write_i = 1'h0, line_error_i = 1'h0;
    logic line_state_read_i = 1'h0, rx_data_ready_i = 1'h0, rx_buffer_read_i = 1'h0;
    logic rx_fifo_nonempty_i = 1'h0, rx_fifo_push_i = 1'h0, thr_empty_i = 1'h0;
    logic thr_write_i = 1'h0, tx_busy_i = 1'h0, tx_pending_i = 1'h0, rx_busy_i = 1'h0;
    logic infrared_rx_decoded_i = 1'h0, infrared_tx_encoded_i = 1'h0, tx_shift_i = 1'h1;
    logic serial_rx_pin_i = 1'h1, infrared_rx_pin_i = 1'h1, tx_serial_i = 1'h1;
    logic slow = 1'h0, rg = 1'h1, dc = 1'h1;
    logic cts_n_i, dsr_n_i, ring_in_n_i, carrier_detect_in_n_i, avs_waitrequest_o;
    logic [31:0] avs_readdata_o;
    logic dtr_n_o, rts_n_o, serial_tx_pin_o, infrared_tx_pin_o, rx_serial_o;
    logic tx_start_ok_o, fifo_mode_o, loopback_o, irq_o, irq_oe_n_o;
    logic [3:0] irq_ident_o;
    int failures = 0;
    int compares = 0;
    byte_t q;
    uart_modem_interrupt_control #(.BIT_CYCLES(4)) uut (.*);
    modem_model mdm (.clk_i(mclk_i), .rts_n_i(rts_n_o), .dtr_n_i(dtr_n_o), .slow_i(slow),
        .ring_n_i(rg), .dcd_n_i(dc), .cts_n_o(cts_n_i), .dsr_n_o(dsr_n_i),
        .ring_n_o(ring_in_n_i), .dcd_n_o(carrier_detect_in_n_i));
    always #2 mclk_i = ~mclk_i;
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            failures++;
            $display("mismatch %0t %h %h", $time, s, e);
        end
    endtask
    task automatic end_sim;
        if (failures == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    // Request held until waitrequest is sampled low at a rising edge
    task automatic acc(input logic w, input logic [3:0] a, input byte_t d);
        int n;
        avs_address_i <= a;
        avs_writedata_i <= {24'h0, d};
        avs_write_i <= w;
        avs_read_i <= !w;
        @(posedge mclk_i);
        for (n = 0; n < 50 && avs_waitrequest_o !== 1'h0; n++) begin
            @(posedge mclk_i);
        end
        if (n == 50) begin
            failures++;
            end_sim;
        end
        q = avs_readdata_o[7:0];
        avs_write_i <= 1'h0;
        avs_read_i <= 1'h0;
        @(posedge mclk_i);
    endtask
    task automatic wr(input logic [3:0] a, input byte_t d);
        acc(1'h1, a, d);
    endtask
    task automatic rdc(input logic [3:0] a, input byte_t e);
        acc(1'h0, a, 8'h00);
        chk(q, e);
    endtask
    task automatic t_regs;
        rdc(4'h2, 8'h01);
        wr(4'h1, 8'hff);
        rdc(4'h1, 8'h0f);
        wr(4'h4, 8'hef);
        rdc(4'h4, 8'h0f);
        chk({dtr_n_o, rts_n_o}, 2'h0);
        wr(4'h4, 8'h04);
        rdc(4'h4, 8'h04);
        chk({dtr_n_o, rts_n_o}, 2'h3);
        wr(4'h7, 8'ha5);
        avs_byteenable_i <= 4'h0;
        wr(4'h7, 8'h5a);
        avs_byteenable_i <= 4'hf;
        rdc(4'h3, 8'h00);
        rdc(4'h7, 8'ha5);
    endtask
    task automatic t_modem;
        slow <= 1'h1;
        cyc(8);
        acc(1'h0, 4'h6, 8'h00);
        wr(4'h4, 8'h02);
        cyc(20);
        rdc(4'h6, 8'h11);
        rg <= 1'h0;
        cyc(12);
        rdc(4'h6, 8'h50);
        rg <= 1'h1;
        cyc(12);
        rdc(4'h6, 8'h14);
        wr(4'h1, 8'h08);
        wr(4'h4, 8'h0a);
        dc <= 1'h0;
        cyc(12);
        chk({irq_o, irq_ident_o}, 5'h10);
        wr(4'h4, 8'h02);
        chk({irq_o, irq_ident_o}, 5'h00);
        wr(4'h1, 8'h00);
        chk(irq_ident_o, 4'h1);
        rdc(4'h6, 8'h98);
        wr(4'h4, 8'h00);
        dc <= 1'h1;
        slow <= 1'h0;
    endtask
    task automatic t_loop;
        wr(4'h1, 8'h08);
        tx_serial_i <= 1'h0;
        tx_shift_i <= 1'h0;
        wr(4'h4, 8'h1f);
        cyc(4);
        chk({dtr_n_o, rts_n_o, irq_oe_n_o, loopback_o, serial_tx_pin_o, rx_serial_o}, 6'h3e);
        chk(irq_ident_o, 4'h0);
        acc(1'h0, 4'h6, 8'h00);
        chk(q & 8'hfb, 8'hfb);
        wr(4'h4, 8'h00);
        wr(4'h8, 8'h01);
        chk({loopback_o, dtr_n_o, serial_tx_pin_o}, 3'h7);
        wr(4'h8, 8'h00);
        tx_serial_i <= 1'h1;
        tx_shift_i <= 1'h1;
    endtask
    task automatic t_ident;
        wr(4'h1, 8'h07);
        thr_empty_i <= 1'h1;
        line_error_i <= 1'h1;
        rx_data_ready_i <= 1'h1;
        cyc(2);
        chk(irq_ident_o, 4'h6);
        wr(4'h1, 8'h03);
        chk(irq_ident_o, 4'h4);
        line_error_i <= 1'h0;
        rx_data_ready_i <= 1'h0;
        wr(4'h1, 8'h07);
        chk(irq_ident_o, 4'h6);
        line_state_read_i <= 1'h1;
        cyc(1);
        line_state_read_i <= 1'h0;
        cyc(2);
        rdc(4'h2, 8'h02);
        chk(irq_ident_o, 4'h1);
        thr_empty_i <= 1'h0;
        cyc(2);
        thr_empty_i <= 1'h1;
        cyc(2);
        thr_write_i <= 1'h1;
        cyc(1);
        thr_write_i <= 1'h0;
        wr(4'h9, 8'h01);
        chk({fifo_mode_o, irq_ident_o}, 5'h11);
        rx_fifo_nonempty_i <= 1'h1;
        cyc(150);
        chk(irq_ident_o, 4'h1);
        cyc(20);
        rdc(4'h2, 8'hcc);
        rx_buffer_read_i <= 1'h1;
        cyc(1);
        rx_buffer_read_i <= 1'h0;
        rx_fifo_nonempty_i <= 1'h0;
        cyc(2);
        chk(irq_ident_o, 4'h1);
        wr(4'h9, 8'h00);
    endtask
    task automatic t_half;
        wr(4'h8, 8'h04);
        serial_rx_pin_i <= 1'h0;
        tx_busy_i <= 1'h1;
        cyc(6);
        chk(rx_serial_o, 1'h1);
        tx_busy_i <= 1'h0;
        cyc(12);
        chk(rx_serial_o, 1'h1);
        cyc(12);
        chk(rx_serial_o, 1'h0);
        rx_busy_i <= 1'h1;
        tx_pending_i <= 1'h1;
        cyc(4);
        rx_busy_i <= 1'h0;
        cyc(1);
        chk(tx_start_ok_o, 1'h0);
        cyc(39);
        chk(tx_start_ok_o, 1'h0);
        cyc(30);
        chk(tx_start_ok_o, 1'h1);
        tx_serial_i <= 1'h0;
        infrared_tx_encoded_i <= 1'h1;
        wr(4'h8, 8'h02);
        cyc(8);
        acc(1'h0, 4'h6, 8'h00);
        chk({q & 8'hf0, serial_tx_pin_o, infrared_tx_pin_o}, 10'h0c3);
        wr(4'h8, 8'h00);
        chk(infrared_tx_pin_o, 1'h0);
    endtask
    task automatic t_reset;
        wr(4'h4, 8'h0b);
        sys_rst_i <= 1'h1;
        cyc(2);
        chk({dtr_n_o, rts_n_o, irq_o, irq_ident_o}, 7'h61);
        sys_rst_i <= 1'h0;
        rdc(4'h4, 8'h00);
    endtask
    initial begin
        repeat (8) @(posedge mclk_i);
        sys_rst_i <= 1'h0;
        t_regs;
        t_modem;
        t_loop;
        t_ident;
        t_half;
        t_reset;
        end_sim;
    end
endmodule

// file: tb/uart_mic_modem_model.sv
// Modem model on the handshake lines of the serial port.
// Assumes active-low lines; it answers in one clock or, when slow, nine.
`timescale 1ns/100ps
module modem_model (
    input wire logic clk_i,
    input wire logic rts_n_i,
    input wire logic dtr_n_i,
    input wire logic slow_i,
    input wire logic ring_n_i,
    input wire logic dcd_n_i,
    output logic cts_n_o,
    output logic dsr_n_o,
    output logic ring_n_o,
    output logic dcd_n_o
);
    logic [15:0] hist = 16'hffff;
    // Clear-to-send follows request, set-ready follows terminal-ready
    always @(posedge clk_i) begin
        hist <= {hist[13:0], rts_n_i, dtr_n_i};
        {cts_n_o, dsr_n_o} <= slow_i ? hist[15:14] : {rts_n_i, dtr_n_i};
        {ring_n_o, dcd_n_o} <= {ring_n_i, dcd_n_i};
    end
endmodule

// file: tb/uart_modem_interrupt_control_monitor.sv
// Checker on the ports of the modem and interrupt control block.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/100ps
module uart_mic_monitor (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic dtr_n_o,
    input wire logic rts_n_o,
    input wire logic serial_tx_pin_o,
    input wire logic fifo_mode_o,
    input wire logic loopback_o,
    input wire logic irq_o,
    input wire logic irq_oe_n_o,
    input wire logic [3:0] irq_ident_o
);
    logic rd_ier;
    logic rd_mcr;
    assign rd_ier = avs_read_i && !avs_waitrequest_o && avs_address_i == 4'h1;
    assign rd_mcr = avs_read_i && !avs_waitrequest_o && avs_address_i == 4'h4;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_req;
        $rose(avs_read_i) || $rose(avs_write_i);
    endsequence
    sequence s_ans;
        avs_waitrequest_o ##1 !avs_waitrequest_o;
    endsequence
    AST_BUS_ANSWER: assert property (s_req |-> s_ans)
        else $error("access not answered on its second cycle");
    AST_IER_HIGH: assert property (rd_ier |-> avs_readdata_o[7:4] == 4'h0)
        else $error("enable upper bits read nonzero");
    AST_MCR_HIGH: assert property (rd_mcr |-> avs_readdata_o[7:5] == 3'h0)
        else $error("control upper bits read nonzero");
    AST_NONE_QUIET: assert property (irq_ident_o == 4'h1 |-> !irq_o)
        else $error("interrupt output with nothing pending");
    AST_BIT3: assert property (!fifo_mode_o |-> !irq_ident_o[3])
        else $error("timeout code outside fifo mode");
    AST_LOOP_PINS: assert property (loopback_o |-> dtr_n_o && rts_n_o)
        else $error("modem output active in loopback");
    AST_IRQ_FLOAT: assert property (irq_oe_n_o == loopback_o)
        else $error("interrupt pin float does not follow loopback");
    AST_SERIAL_TX_PIN_MARK: assert property (loopback_o |-> serial_tx_pin_o)
        else $error("serial out not at mark in loopback");
endmodule
bind uart_modem_interrupt_control uart_mic_monitor mon (.*);
